/* File: hdl/bbfc_defs.svh */
// offsets, field positions, command codes and timing counts of the flash host controller
// assumes a 100 MHz clock and the flash command set of a two-cycle boot-block part
`ifndef BBFC_DEFS_SVH
`define BBFC_DEFS_SVH
// ----------------------------------------
// software register offsets
// ----------------------------------------
`define BBFC_REG_CTRL 4'h0
`define BBFC_REG_ADDR 4'h4
`define BBFC_REG_DATA 4'h8
`define BBFC_REG_STAT 4'hC
// control register fields
`define BBFC_CTRL_OP_MSB 2
`define BBFC_CTRL_WORD 3
`define BBFC_CTRL_BOOT 4
`define BBFC_CTRL_HV 5
`define BBFC_CTRL_PD 6
// status register fields
`define BBFC_STAT_BUSY 8
`define BBFC_STAT_REFUSED 9
`define BBFC_STAT_TIMEOUT 10
`define BBFC_STAT_PATH_LSB 11
// ----------------------------------------
// flash command codes and device status bits
// ----------------------------------------
`define BBFC_CMD_ERASE_SETUP 8'h20
`define BBFC_CMD_ERASE_CONFIRM 8'hD0
`define BBFC_CMD_WRITE_SETUP 8'h40
`define BBFC_CMD_WRITE_SETUP_ALT 8'h10
`define BBFC_CMD_READ_ARRAY 8'hFF
`define BBFC_SR_READY 7
`define BBFC_SR_SUSPEND 6
`define BBFC_SR_ERASE_FAIL 5
`define BBFC_SR_PROG_FAIL 4
`define BBFC_SR_SUPPLY_FAULT 3
// boot block spans 16 KB, so its address bits start here
`define BBFC_BOOT_LSB 14
// ----------------------------------------
// timing
// ----------------------------------------
`define BBFC_CLK_NS 10
`define BBFC_ACCESS_NS 80
`define BBFC_STROBE_NS 50
`define BBFC_ACCESS_CYC ((`BBFC_ACCESS_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_STROBE_CYC ((`BBFC_STROBE_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_POLL_LIMIT 100000
`endif

/* File: hdl/bbfc_pkg.sv */
// types shared by the flash host controller modules
// assumes nothing beyond a SystemVerilog compiler
package bbfc_pkg;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000, OP_READ = 3'b001, OP_PROG = 3'b010,
      OP_ERASE = 3'b011, OP_IDENT = 3'b100, OP_RDARR = 3'b101
   } bbfc_op_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_FIRST = 3'b001, S_SECOND = 3'b010,
      S_POLL = 3'b011, S_FINISH = 3'b100, S_READ = 3'b101
   } bbfc_state_e;
   typedef enum logic [1:0] {
      P_ARRAY = 2'b00, P_STATUS = 2'b01, P_IDENT = 2'b10
   } bbfc_path_e;
   typedef enum logic [2:0] {
      Q_IDLE = 3'b000, Q_SETUP = 3'b001, Q_STROBE = 3'b010,
      Q_HOLD = 3'b011, Q_READ = 3'b100
   } bbfc_pin_e;
endpackage : bbfc_pkg

/* File: hdl/bbfc_cyc_if.sv */
// one bus cycle request from the operation sequencer to the pin sequencer
// assumes both ends share clk_i
interface bbfc_cyc_if #(parameter int ADDR_W = 19, parameter int DATA_W = 16);
   logic req;
   logic wr;
   logic id;
   logic word;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;
   modport ctl (output req, wr, id, word, addr, wdata, input done, rdata);
   modport seq (input req, wr, id, word, addr, wdata, output done, rdata);
endinterface : bbfc_cyc_if

/* File: hdl/bbfc_pin_seq.sv */
// pin sequencer: turns one cycle request into chip select, strobe and data pin timing
// assumes pin inputs are synchronous to clk_i and the flash needs no clock
module bbfc_pin_seq
   import bbfc_pkg::*;
#(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   bbfc_cyc_if.seq cyc,
   output logic chip_select_n_o,
   output logic output_enable_n_o,
   output logic write_strobe_n_o,
   output logic id_hv_o,
   output logic [ADDR_W-1:0] flash_addr_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [DATA_W-1:0] dq_i
);
`include "bbfc_defs.svh"
   localparam logic [7:0] ACC_CYC = 8'(`BBFC_ACCESS_CYC);
   localparam logic [7:0] STB_CYC = 8'(`BBFC_STROBE_CYC);

   bbfc_pin_e q;
   logic [7:0] cnt;
   wire cnt_end = (cnt == 8'h00);

   // ----------------------------------------
   // cycle timing
   // ----------------------------------------
   // strobe rises one cycle before chip select so the flash latches on the strobe edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q <= Q_IDLE;
         cnt <= 8'h00;
         chip_select_n_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         id_hv_o <= 1'b0;
         flash_addr_o <= '0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
      end else if (ce_i) begin
         cyc.done <= 1'b0;
         case (q)
            Q_IDLE: if (cyc.req) begin
               chip_select_n_o <= 1'b0;
               flash_addr_o <= cyc.addr;
               dq_o <= cyc.wdata;
               dq_oe_o <= cyc.wr;
               id_hv_o <= cyc.id & ~cyc.wr;
               q <= Q_SETUP;
            end
            Q_SETUP: begin
               if (cyc.wr) begin
                  write_strobe_n_o <= 1'b0;
                  cnt <= STB_CYC - 8'h01;
                  q <= Q_STROBE;
               end else begin
                  output_enable_n_o <= 1'b0;
                  cnt <= ACC_CYC - 8'h01;
                  q <= Q_READ;
               end
            end
            Q_STROBE: begin
               cnt <= cnt - 8'h01;
               if (cnt_end) begin
                  write_strobe_n_o <= 1'b1;
                  q <= Q_HOLD;
               end
            end
            Q_HOLD: begin
               chip_select_n_o <= 1'b1;
               dq_oe_o <= 1'b0;
               cyc.done <= 1'b1;
               q <= Q_IDLE;
            end
            Q_READ: begin
               cnt <= cnt - 8'h01;
               if (cnt_end) begin
                  cyc.rdata <= dq_i;
                  chip_select_n_o <= 1'b1;
                  output_enable_n_o <= 1'b1;
                  id_hv_o <= 1'b0;
                  cyc.done <= 1'b1;
                  q <= Q_IDLE;
               end
            end
            default: q <= Q_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_strobe_rise_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(write_strobe_n_o) |-> !chip_select_n_o ##1 chip_select_n_o)
      else $error("strobe did not rise before chip select");
   a_dq_drive_safe: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      dq_oe_o |-> (output_enable_n_o && !chip_select_n_o))
      else $error("data driven while flash may drive");
   a_ident_addr_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      id_hv_o |-> (flash_addr_o[ADDR_W-1:1] == '0 && !output_enable_n_o || q == Q_SETUP))
      else $error("id read with upper address bits set");
   a_byte_data_narrow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!write_strobe_n_o && !cyc.word) |-> dq_o[DATA_W-1:8] == '0)
      else $error("byte mode write drives upper lines");
endmodule : bbfc_pin_seq

/* File: hdl/bbfc_host.sv */
// host controller for a two-cycle boot-block parallel flash
// assumes single 100 MHz clock, software on a plain strobe port, level shifters on the
// unlock, id and program supply selects outside this block
// Operation
// - erase is setup 20h then confirm D0h, nothing between them
// - program is setup 40h then the data write at the target address
// - after program or erase, host writes FFh before reading the array
// - id read with A9 at id voltage, all address bits low except bit 0
`include "bbfc_defs.svh"
module bbfc_host
   import bbfc_pkg::*;
#(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16,
   parameter bit TOP_BOOT = 1'b1,
   parameter int POLL_LIMIT = `BBFC_POLL_LIMIT
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic chip_select_n_o,
   output logic output_enable_n_o,
   output logic write_strobe_n_o,
   output logic [ADDR_W-1:0] flash_addr_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [DATA_W-1:0] dq_i,
   output logic reset_powerdown_n_o,
   output logic unlock_hv_o,
   output logic boot_unlock_o,
   output logic id_hv_o,
   output logic program_supply_o,
   output logic width_select_n_o
);

   bbfc_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

   // ----------------------------------------
   // state
   // ----------------------------------------
   bbfc_state_e state;
   bbfc_state_e next_state;
   bbfc_op_e op;
   bbfc_path_e path;
   logic word_mode;
   logic powerdown;
   logic [ADDR_W-1:0] tgt_addr;
   logic [DATA_W-1:0] tgt_data;
   logic [DATA_W-1:0] read_data;
   logic [7:0] dev_status;
   logic refused;
   logic timeout;
   logic pend;
   logic req;
   logic dev_busy;
   logic [7:0] last_wdata;
   logic [31:0] poll_cnt;

   // ----------------------------------------
   // software decode
   // ----------------------------------------
   wire busy = (state != S_IDLE);
   wire ctrl_wr = wr_i && (addr_i == `BBFC_REG_CTRL) && !busy;
   wire addr_wr = wr_i && (addr_i == `BBFC_REG_ADDR) && !busy;
   wire data_wr = wr_i && (addr_i == `BBFC_REG_DATA) && !busy;
   wire [2:0] new_op = wdata_i[`BBFC_CTRL_OP_MSB:0];
   wire new_pd = wdata_i[`BBFC_CTRL_PD];
   wire new_unlock = wdata_i[`BBFC_CTRL_BOOT] | wdata_i[`BBFC_CTRL_HV];
   wire new_alter = (new_op == OP_PROG) || (new_op == OP_ERASE);
   // boot block at the top or bottom of the map
   wire boot_hit = TOP_BOOT ? (&tgt_addr[ADDR_W-1:`BBFC_BOOT_LSB])
                            : ~(|tgt_addr[ADDR_W-1:`BBFC_BOOT_LSB]);
   wire refuse = ctrl_wr && new_alter && ((boot_hit && !new_unlock) || new_pd);
   wire start = ctrl_wr && (new_op != OP_NONE) && !new_pd && !refuse;
   wire [31:0] ctrl_rd = {25'h0000000, powerdown, unlock_hv_o, boot_unlock_o, word_mode, op};
   wire [31:0] stat_rd = {19'h00000, path, timeout, refused, busy, dev_status};
   wire [31:0] rd_mux = (addr_i == `BBFC_REG_CTRL) ? ctrl_rd :
                        (addr_i == `BBFC_REG_ADDR) ? 32'(tgt_addr) :
                        (addr_i == `BBFC_REG_DATA) ? 32'(read_data) :
                        (addr_i == `BBFC_REG_STAT) ? stat_rd : 32'h00000000;

   // ----------------------------------------
   // cycle request selection
   // ----------------------------------------
   wire launch = busy && !pend;
   wire is_prog = (op == OP_PROG);
   wire ready = cyc.rdata[`BBFC_SR_READY];
   // at or past the limit: a poll read rarely ends on the exact limit cycle
   wire poll_to = (poll_cnt >= 32'(POLL_LIMIT - 1));
   wire poll_end = (state == S_POLL) && cyc.done && (ready || poll_to);
   // byte mode sends only the low byte, word mode the full word
   wire [DATA_W-1:0] prog_data = word_mode ? tgt_data : {{(DATA_W-8){1'b0}}, tgt_data[7:0]};
   wire [7:0] first_cmd = is_prog ? `BBFC_CMD_WRITE_SETUP : `BBFC_CMD_ERASE_SETUP;
   wire [7:0] cmd_byte = (state == S_FIRST) ? first_cmd :
                         (state == S_SECOND) ? `BBFC_CMD_ERASE_CONFIRM : `BBFC_CMD_READ_ARRAY;
   assign cyc.req = req;
   assign cyc.wr = (state == S_FIRST) || (state == S_SECOND) || (state == S_FINISH);
   assign cyc.id = (op == OP_IDENT);
   assign cyc.word = word_mode;
   assign cyc.addr = (op == OP_IDENT) ? {{(ADDR_W-1){1'b0}}, tgt_addr[0]} : tgt_addr;
   assign cyc.wdata = (state == S_SECOND && is_prog) ? prog_data
                                                      : {{(DATA_W-8){1'b0}}, cmd_byte};

   // ----------------------------------------
   // operation sequence
   // ----------------------------------------
   // each state but S_IDLE issues one bus cycle and moves on when the pin sequencer reports done; S_POLL repeats its read until ready or the limit
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: if (start) begin
            case (bbfc_op_e'(new_op))
               OP_READ, OP_IDENT: next_state = S_READ;
               OP_PROG, OP_ERASE: next_state = S_FIRST;
               OP_RDARR: next_state = S_FINISH;
               default: next_state = S_IDLE;
            endcase
         end
         S_FIRST: if (cyc.done) next_state = S_SECOND;
         S_SECOND: if (cyc.done) next_state = S_POLL;
         S_POLL: if (poll_end) next_state = S_FINISH;
         S_FINISH: if (cyc.done) next_state = S_IDLE;
         S_READ: if (cyc.done) next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   // sequencer state and request handshake
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= S_IDLE;
         req <= 1'b0;
         pend <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         req <= launch;
         pend <= launch | (pend & ~cyc.done);
      end
   end

   // software-owned settings; held constant for the whole operation
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         op <= OP_NONE;
         word_mode <= 1'b0;
         powerdown <= 1'b0;
         boot_unlock_o <= 1'b0;
         unlock_hv_o <= 1'b0;
         tgt_addr <= '0;
         tgt_data <= '0;
      end else if (ce_i) begin
         if (ctrl_wr) begin
            op <= bbfc_op_e'(new_op);
            word_mode <= wdata_i[`BBFC_CTRL_WORD];
            powerdown <= new_pd;
            boot_unlock_o <= wdata_i[`BBFC_CTRL_BOOT];
            unlock_hv_o <= wdata_i[`BBFC_CTRL_HV];
         end
         if (addr_wr) tgt_addr <= wdata_i[ADDR_W-1:0];
         if (data_wr) tgt_data <= wdata_i[DATA_W-1:0];
      end
   end

   // device view: status copy, read path and error flags
   // a fresh start clears refused and timeout so each result stands alone
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         path <= P_ARRAY;
         dev_status <= 8'h00;
         read_data <= '0;
         refused <= 1'b0;
         timeout <= 1'b0;
         dev_busy <= 1'b0;
      end else if (ce_i) begin
         if (ctrl_wr && new_pd) begin
            dev_status <= 8'h00;
            path <= P_ARRAY;
            dev_busy <= 1'b0;
         end
         if (ctrl_wr) refused <= refuse;
         if (start) timeout <= 1'b0;
         if (state == S_SECOND && cyc.done) path <= P_STATUS;
         if (state == S_FINISH && cyc.done) path <= P_ARRAY;
         if (state == S_POLL && cyc.done) begin
            dev_status <= cyc.rdata[7:0];
            dev_busy <= ~ready;
            timeout <= ~ready & poll_to;
         end
         if (state == S_READ && cyc.done) begin
            read_data <= (word_mode || op == OP_IDENT) ? cyc.rdata : {{(DATA_W-8){1'b0}}, cyc.rdata[7:0]};
         end
      end
   end

   // poll time limit and write history
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         poll_cnt <= 32'h00000000;
         last_wdata <= 8'hFF;
      end else if (ce_i) begin
         poll_cnt <= (state == S_POLL) ? poll_cnt + 32'h00000001 : 32'h00000000;
         if (launch && cyc.wr) last_wdata <= cyc.wdata[7:0];
      end
   end

   // pin-level selects; supply stays up from setup through the engine's run
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         program_supply_o <= 1'b0;
         reset_powerdown_n_o <= 1'b1;
         width_select_n_o <= 1'b1;
         rdata_o <= 32'h00000000;
      end else if (ce_i) begin
         program_supply_o <= (next_state == S_FIRST) || (next_state == S_SECOND) || (next_state == S_POLL);
         reset_powerdown_n_o <= ctrl_wr ? ~new_pd : reset_powerdown_n_o;
         width_select_n_o <= ctrl_wr ? ~wdata_i[`BBFC_CTRL_WORD] : width_select_n_o;
         rdata_o <= rd_i ? rd_mux : 32'h00000000;
      end
   end

   // ----------------------------------------
   // pin sequencer
   // ----------------------------------------
   bbfc_pin_seq #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_pins (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .cyc(cyc.seq),
      .chip_select_n_o(chip_select_n_o),
      .output_enable_n_o(output_enable_n_o),
      .write_strobe_n_o(write_strobe_n_o),
      .id_hv_o(id_hv_o),
      .flash_addr_o(flash_addr_o),
      .dq_o(dq_o),
      .dq_oe_o(dq_oe_o),
      .dq_i(dq_i)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_confirm_after_setup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (launch && cyc.wr && state == S_SECOND && !is_prog) |-> last_wdata == `BBFC_CMD_ERASE_SETUP)
      else $error("erase confirm without setup just before");
   a_data_after_setup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (launch && state == S_SECOND && is_prog) |-> last_wdata == `BBFC_CMD_WRITE_SETUP)
      else $error("program data without setup just before");
   a_array_restored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(program_supply_o) |-> ##[1:40] (!busy && last_wdata == `BBFC_CMD_READ_ARRAY))
      else $error("read array not issued after alter");
   a_boot_guarded: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (launch && state == S_SECOND && boot_hit) |-> (boot_unlock_o || unlock_hv_o))
      else $error("boot block altered while locked");
   a_supply_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == S_SECOND || state == S_POLL) |-> program_supply_o)
      else $error("program supply dropped during alter");
   a_cmd_low_lines: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (launch && cyc.wr && !(state == S_SECOND && is_prog)) |-> cyc.wdata[DATA_W-1:8] == '0)
      else $error("command on upper data lines");
   a_busy_no_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (dev_busy && launch) |-> !cyc.wr)
      else $error("write issued while device busy");
   a_pd_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !reset_powerdown_n_o |-> (dev_status == 8'h00 && path == P_ARRAY && !busy))
      else $error("power-down left status or mode");
   a_status_after_alter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == S_POLL) |-> path == P_STATUS)
      else $error("poll without status read path");
endmodule : bbfc_host

/* File: sim/bbfc_flash_model.sv */
// behavioural boot-block flash device facing the host controller pins
// assumes the top boot map, 19 byte address lines and pins from a clocked host
module bbfc_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_ID = 8'h3C, // arbitrary value
   parameter int BUSY_NS = 200
) (
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [18:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic reset_powerdown_n_i,
   input wire logic unlock_hv_i,
   input wire logic boot_unlock_i,
   input wire logic id_hv_i,
   input wire logic supply_i,
   input wire logic width_select_n_i,
   output logic [15:0] dq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [logic [18:0]];
   logic [1:0] mode = 2'h0;
   logic [1:0] setup = 2'h0;
   logic [7:0] stat = 8'h00;
   logic [15:0] last = 16'h0000;
   time ready_at = 0;
   // block index, block 4 is the boot block at the top
   function automatic logic [2:0] blk(input logic [18:0] a);
      if (a >= 19'h7C000) return 3'h4;
      if (a >= 19'h7A000) return 3'h5;
      if (a >= 19'h78000) return 3'h6;
      return {1'b0, a[18:17]};
   endfunction : blk
   // read path source picked by the id select, then by the last command
   function automatic logic [15:0] rd_val();
      if (id_hv_i) return (addr_i[18:1] == 0) ? {8'h00, addr_i[0] ? PART_ID : MAKER_ID} : 16'hDEAD;
      if (mode == 2'h1) return {8'h00, $time >= ready_at, stat[6:0]};
      return mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
   endfunction : rd_val
   // engine: a locked boot block or a missing supply fails instead of altering
   task automatic alter(input logic [18:0] a, input logic [15:0] d, input bit erase);
      logic [18:0] ks[$];
      logic bad;
      bad = !supply_i || (blk(a) == 3'h4 && !unlock_hv_i && !boot_unlock_i);
      stat = 8'h00;
      stat[3] = !supply_i;
      stat[erase ? 5 : 4] = bad;
      if (!bad && erase) begin
         foreach (mem[k]) if (blk(k) == blk(a)) ks.push_back(k);
         foreach (ks[i]) mem.delete(ks[i]);
      end else if (!bad) begin
         mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & (width_select_n_i ? {8'hFF, d[7:0]} : d);
      end
      ready_at = $time + BUSY_NS;
      mode = 2'h1;
   endtask : alter
   // capture on whichever of select or strobe rises first; busy engine ignores all
   always @(posedge we_n_i or posedge cs_n_i) begin
      if (reset_powerdown_n_i && (cs_n_i ^ we_n_i) && $time >= ready_at) begin
         if (setup == 2'h1) alter(addr_i, dq_i, 1'b0);
         else if (setup == 2'h2 && dq_i[7:0] == 8'hD0) alter(addr_i, dq_i, 1'b1);
         else if (dq_i[7:0] == 8'hFF) mode = 2'h0;
         if (setup != 2'h0) setup = 2'h0;
         else if (dq_i[7:0] == 8'h20) setup = 2'h2;
         else if (dq_i[7:0] inside {8'h40, 8'h10}) setup = 2'h1;
      end
   end
   // power-down clears status and drops back to array read
   always @(negedge reset_powerdown_n_i) begin
      stat = 8'h00;
      mode = 2'h0;
      setup = 2'h0;
      ready_at = 0;
   end
   // released lines show the inverse of the last value, never a stale copy
   always #1 begin
      if (!cs_n_i && !oe_n_i && we_n_i && reset_powerdown_n_i) begin
         last = rd_val();
         dq_o = last;
      end else dq_o = ~last;
   end
endmodule : bbfc_flash_model

/* File: sim/tb_bbfc_host.sv */
// self-checking bench of the flash host controller against a behavioural flash
// assumes the register map and command codes of the shared header
`include "bbfc_defs.svh"
module tb_bbfc_host;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [6:0] c;
      logic [18:0] a;
      logic [15:0] d;
      logic [15:0] e;
      logic [10:0] s;
      logic [10:0] m;
   } bbfc_row_s;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic ce_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] rdata_o, v;
   logic chip_select_n_o, output_enable_n_o, write_strobe_n_o, dq_oe_o, reset_powerdown_n_o;
   logic unlock_hv_o, boot_unlock_o, id_hv_o, program_supply_o, width_select_n_o;
   logic [18:0] flash_addr_o;
   logic [15:0] dq_o, dq_i;
   int miscompares = 0;
   int comparisons = 0;
   bbfc_row_s rows [16];
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   bbfc_host #(.TOP_BOOT(1'b1), .POLL_LIMIT(64)) i_dut (.clk_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .chip_select_n_o, .output_enable_n_o, .write_strobe_n_o, .flash_addr_o, .dq_o,
      .dq_oe_o, .dq_i, .reset_powerdown_n_o, .unlock_hv_o, .boot_unlock_o, .id_hv_o, .program_supply_o,
      .width_select_n_o);
   // undriven data lines reach the flash inverted, so a missing output enable garbles every command
   bbfc_flash_model i_flash (.cs_n_i(chip_select_n_o), .oe_n_i(output_enable_n_o), .we_n_i(write_strobe_n_o),
      .addr_i(flash_addr_o), .dq_i(dq_oe_o ? dq_o : ~dq_o), .reset_powerdown_n_i(reset_powerdown_n_o),
      .unlock_hv_i(unlock_hv_o), .boot_unlock_i(boot_unlock_o), .id_hv_i(id_hv_o), .supply_i(program_supply_o),
      .width_select_n_i(width_select_n_o), .dq_o(dq_i));
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd
   // bounded poll of the busy flag; running out ends the run
   task automatic idle();
      for (int i = 0; i < 3000; i++) begin
         rd(`BBFC_REG_STAT);
         if (v[`BBFC_STAT_BUSY] === 1'b0) return;
      end
      miscompares++;
      summarize();
   endtask : idle
   initial begin
      rows = '{'{7'h0A, 19'h00010, 16'h1234, 16'h0, 11'h080, 11'h1FF}, '{7'h09, 19'h00010, 16'h0, 16'h1234, 11'h0, 11'h100},
         '{7'h02, 19'h00021, 16'h00A5, 16'h0, 11'h080, 11'h1FF}, '{7'h01, 19'h00021, 16'h0, 16'h00A5, 11'h0, 11'h100},
         '{7'h0A, 19'h40000, 16'h5555, 16'h0, 11'h080, 11'h1FF}, '{7'h03, 19'h00010, 16'h0, 16'h0, 11'h080, 11'h1FF},
         '{7'h09, 19'h00010, 16'h0, 16'hFFFF, 11'h0, 11'h100}, '{7'h09, 19'h40000, 16'h0, 16'h5555, 11'h0, 11'h100},
         '{7'h0C, 19'h00000, 16'h0, 16'h005A, 11'h0, 11'h100}, '{7'h0C, 19'h00001, 16'h0, 16'h003C, 11'h0, 11'h100},
         '{7'h0A, 19'h7C002, 16'h9ABC, 16'h0, 11'h200, 11'h200}, '{7'h1A, 19'h7C002, 16'h9ABC, 16'h0, 11'h080, 11'h1FF},
         '{7'h09, 19'h7C002, 16'h0, 16'h9ABC, 11'h0, 11'h100}, '{7'h23, 19'h7C000, 16'h0, 16'h0, 11'h080, 11'h1FF},
         '{7'h09, 19'h7C002, 16'h0, 16'hFFFF, 11'h0, 11'h100}, '{7'h0D, 19'h00000, 16'h0, 16'h0, 11'h0, 11'h100}};
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // one row: address, data, then the operation, wait, compare
      foreach (rows[i]) begin
         wr(`BBFC_REG_ADDR, {13'h0, rows[i].a});
         wr(`BBFC_REG_DATA, {16'h0, rows[i].d});
         wr(`BBFC_REG_CTRL, {25'h0, rows[i].c});
         idle();
         chk("status", {21'h0, v[10:0] & rows[i].m}, {21'h0, rows[i].s});
         if (rows[i].c[2:0] inside {3'h1, 3'h4}) begin
            rd(`BBFC_REG_DATA);
            chk("data", v, {16'h0, rows[i].e});
         end
      end
      // unmapped offset
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2);
      chk("unmapped", v, 32'h0);
      // a write right behind the start lands while busy and must be lost
      wr(`BBFC_REG_ADDR, 32'h100);
      wr(`BBFC_REG_DATA, 32'h0F0F);
      wr(`BBFC_REG_CTRL, 32'h0A);
      wr(`BBFC_REG_ADDR, 32'h200);
      idle();
      wr(`BBFC_REG_CTRL, 32'h09);
      idle();
      rd(`BBFC_REG_DATA);
      chk("busy drop", v, 32'h0F0F);
      // power-down, then array read without any command
      wr(`BBFC_REG_CTRL, 32'h40);
      rd(`BBFC_REG_STAT);
      chk("pd pin", {31'h0, reset_powerdown_n_o}, 32'h0);
      chk("pd stat", {22'h0, v[12:11], v[7:0]}, 32'h0);
      wr(`BBFC_REG_CTRL, 32'h0);
      wr(`BBFC_REG_CTRL, 32'h09);
      idle();
      rd(`BBFC_REG_DATA);
      chk("after pd", v, 32'h0F0F);
      // with the clock enable low a register write is not taken
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(`BBFC_REG_ADDR, 32'h300);
      ce_i <= 1'b1;
      rd(`BBFC_REG_ADDR);
      chk("ce hold", v, 32'h100);
      // reset in mid-read must leave every control pin idle
      wr(`BBFC_REG_CTRL, 32'h09);
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("rst pins", {22'h0, chip_select_n_o, output_enable_n_o, write_strobe_n_o, dq_oe_o, unlock_hv_o,
         boot_unlock_o, id_hv_o, program_supply_o, reset_powerdown_n_o, width_select_n_o}, 32'h383);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // the first operation after a mid-run reset must still work
      wr(`BBFC_REG_ADDR, 32'h100);
      wr(`BBFC_REG_CTRL, 32'h09);
      idle();
      rd(`BBFC_REG_DATA);
      chk("after rst", v, 32'h0F0F);
      summarize();
   end
endmodule : tb_bbfc_host
